// [src/txld_ctrl.sv]
// transmit line driver control: template rom, sample array, high-z, over-current status
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/100ps
module txld_ctrl #(
  parameter int SAMPLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic global_oe_pin,
  input wire logic tx_overcurrent,
  input wire logic shaper_tip,
  input wire logic shaper_ring,
  input wire logic [4:0] sample_rd_index,
  output logic [6:0] sample_rd_value,
  output logic line_out_tip,
  output logic line_out_tip_oe,
  output logic line_out_ring,
  output logic line_out_ring_oe,
  output logic current_limit,
  output logic tx_multifunction_pin,
  output logic irq_n
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // sample index is 1-based; anything outside 1..20 reads as zero
  function automatic logic idx_ok(input logic [4:0] idx);
    return (idx != 5'h00) && (idx <= 5'(SAMPLES));
  endfunction

  function automatic logic [6:0] rom_sample(input logic [2:0] sel, input logic [4:0] idx);
    logic [4:0] pos;
    pos = idx - 5'h01;
    if (idx_ok(idx)) begin
      return txld_pkg::TEMPLATE_ROM[sel][pos];
    end
    return 7'h00;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  txld_pkg::txld_cfg_t cfg_reg;
  txld_pkg::txld_ahb_req_t req_reg;
  logic [3:0] pulse_sel_reg;
  logic [4:0] sample_index_reg;
  logic sample_dir_reg;
  logic [6:0] sample_value_reg;
  logic [6:0] sample_mem [SAMPLES];
  logic overcurrent_status_reg;
  logic overcurrent_irq_latched_reg;
  logic overcurrent_edge_select_reg;
  logic overcurrent_irq_mask_reg;
  logic tmf_select_reg;
  logic go_reg;
  logic line_out_tip_reg;
  logic line_out_ring_reg;
  logic [6:0] sample_rd_value_reg;
  logic wr_en;
  logic [6:0] lookup_value;
  logic oc_event;
  logic oc_clear;
  logic drive_ok;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // zero wait states, so hready is always offered and response is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ce && req_reg.valid && req_reg.write;

  // address phase capture
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else if (ce && hready) begin
      req_reg.valid <= hsel && (htrans == txld_pkg::HTRANS_NONSEQ);
      req_reg.write <= hwrite;
      req_reg.addr <= haddr[7:0];
    end
  end

  // configuration registers written in the data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_reg <= txld_pkg::TX_CONFIG_RST;
      pulse_sel_reg <= txld_pkg::PULSE_SEL_RST;
      overcurrent_edge_select_reg <= 1'b0;
      overcurrent_irq_mask_reg <= 1'b1;
      tmf_select_reg <= 1'b0;
    end else if (wr_en) begin
      if (req_reg.addr == txld_pkg::TX_CONFIG_REG_0_OFS) begin
        cfg_reg <= hwdata[6:0];
      end else if (req_reg.addr == txld_pkg::PULSE_SEL_REG_OFS) begin
        pulse_sel_reg <= hwdata[3:0];
      end else if (req_reg.addr == txld_pkg::IRQ_EDGE_SELECT_REG_OFS) begin
        overcurrent_edge_select_reg <= hwdata[txld_pkg::OC_BIT];
      end else if (req_reg.addr == txld_pkg::IRQ_MASK_REG_0_OFS) begin
        overcurrent_irq_mask_reg <= hwdata[txld_pkg::OC_BIT];
      end else if (req_reg.addr == txld_pkg::TMF_SELECT_REG_OFS) begin
        tmf_select_reg <= hwdata[0];
      end
    end
  end

  // read mux; unmapped offsets and reserved bits read as zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (req_reg.addr == txld_pkg::TX_CONFIG_REG_0_OFS) begin
      hrdata[6:0] = cfg_reg;
    end else if (req_reg.addr == txld_pkg::PULSE_SEL_REG_OFS) begin
      hrdata[3:0] = pulse_sel_reg;
    end else if (req_reg.addr == txld_pkg::WAVEFORM_ACCESS_CONTROL_OFS) begin
      hrdata[6:0] = {go_reg, sample_dir_reg, sample_index_reg};
    end else if (req_reg.addr == txld_pkg::WAVEFORM_SAMPLE_DATA_OFS) begin
      hrdata[6:0] = sample_value_reg;
    end else if (req_reg.addr == txld_pkg::STATUS_REG_0_OFS) begin
      hrdata[txld_pkg::OC_BIT] = overcurrent_status_reg;
    end else if (req_reg.addr == txld_pkg::IRQ_STATUS_REG_0_OFS) begin
      hrdata[txld_pkg::OC_BIT] = overcurrent_irq_latched_reg;
    end else if (req_reg.addr == txld_pkg::IRQ_EDGE_SELECT_REG_OFS) begin
      hrdata[txld_pkg::OC_BIT] = overcurrent_edge_select_reg;
    end else if (req_reg.addr == txld_pkg::IRQ_MASK_REG_0_OFS) begin
      hrdata[txld_pkg::OC_BIT] = overcurrent_irq_mask_reg;
    end else if (req_reg.addr == txld_pkg::TMF_SELECT_REG_OFS) begin
      hrdata[0] = tmf_select_reg;
    end
  end

  // ---------------------------------------------------------------
  // waveform sample access
  // ---------------------------------------------------------------
  // user array when top select bit is set, else the standard template
  assign lookup_value = pulse_sel_reg[txld_pkg::PULS_USER_BIT] ?
    (idx_ok(sample_index_reg) ? sample_mem[sample_index_reg - 5'h01] : 7'h00) :
    rom_sample(pulse_sel_reg[2:0], sample_index_reg);

  // access control and data registers; go runs one cycle then self-clears
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample_index_reg <= 5'h00;
      sample_dir_reg <= 1'b0;
      go_reg <= 1'b0;
      sample_value_reg <= 7'h00;
    end else if (ce) begin
      go_reg <= 1'b0;
      if (wr_en && req_reg.addr == txld_pkg::WAVEFORM_ACCESS_CONTROL_OFS) begin
        sample_index_reg <= hwdata[4:0];
        sample_dir_reg <= hwdata[txld_pkg::AWG_DIR_BIT];
        go_reg <= hwdata[txld_pkg::AWG_GO_BIT];
      end else if (wr_en && req_reg.addr == txld_pkg::WAVEFORM_SAMPLE_DATA_OFS) begin
        sample_value_reg <= hwdata[6:0];
      end else if (go_reg && sample_dir_reg) begin
        sample_value_reg <= lookup_value;
      end
    end
  end

  // user sample array; write request stores the data register
  always_ff @(posedge sys_clk) begin
    if (ce && go_reg && !sample_dir_reg && idx_ok(sample_index_reg)) begin
      sample_mem[sample_index_reg - 5'h01] <= sample_value_reg;
    end
  end

  // sample port toward the shaper, one cycle of latency
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample_rd_value_reg <= 7'h00;
    end else if (ce) begin
      if (pulse_sel_reg[txld_pkg::PULS_USER_BIT] && idx_ok(sample_rd_index)) begin
        sample_rd_value_reg <= sample_mem[sample_rd_index - 5'h01];
      end else if (pulse_sel_reg[txld_pkg::PULS_USER_BIT]) begin
        sample_rd_value_reg <= 7'h00;
      end else begin
        sample_rd_value_reg <= rom_sample(pulse_sel_reg[2:0], sample_rd_index);
      end
    end
  end
  assign sample_rd_value = sample_rd_value_reg;

  // ---------------------------------------------------------------
  // over-current status and interrupt
  // ---------------------------------------------------------------
  assign oc_event = (tx_overcurrent != overcurrent_status_reg) &&
    (tx_overcurrent || overcurrent_edge_select_reg);
  assign oc_clear = wr_en && (req_reg.addr == txld_pkg::IRQ_STATUS_REG_0_OFS) &&
    hwdata[txld_pkg::OC_BIT];

  // status mirrors the input; a new edge beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      overcurrent_status_reg <= 1'b0;
      overcurrent_irq_latched_reg <= 1'b0;
    end else if (ce) begin
      overcurrent_status_reg <= tx_overcurrent;
      if (oc_event) begin
        overcurrent_irq_latched_reg <= 1'b1;
      end else if (oc_clear) begin
        overcurrent_irq_latched_reg <= 1'b0;
      end
    end
  end

  // mask bit set suppresses the shared interrupt
  assign irq_n = !(overcurrent_irq_latched_reg && !overcurrent_irq_mask_reg);
  // active high indication when selected, else held low
  assign tx_multifunction_pin = tmf_select_reg && overcurrent_status_reg;

  // ---------------------------------------------------------------
  // line driver
  // ---------------------------------------------------------------
  // enables are combinational so high-z does not wait for a clock edge
  assign drive_ok = global_oe_pin && cfg_reg.oe && !cfg_reg.power_off &&
    !(tx_overcurrent && cfg_reg.hiz_oc);
  assign line_out_tip_oe = drive_ok;
  assign line_out_ring_oe = drive_ok && !cfg_reg.single_ended;
  // limiter only applies while the driver keeps driving
  assign current_limit = tx_overcurrent && !cfg_reg.hiz_oc && drive_ok;

  // data stays registered while high-z, so the shaper path is unaffected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      line_out_tip_reg <= 1'b0;
      line_out_ring_reg <= 1'b0;
    end else if (ce) begin
      line_out_tip_reg <= shaper_tip;
      line_out_ring_reg <= shaper_ring;
    end
  end
  assign line_out_tip = line_out_tip_reg;
  assign line_out_ring = line_out_ring_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_rom_t1_short: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h3 && sample_rd_index == 5'h0A) |=>
    (sample_rd_value == 7'h50 || $changed(pulse_sel_reg)))
    else $error("T1 133-266 sample ten wrong");
  a_rom_t1_mid: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h4 && sample_rd_index == 5'h02) |=>
    (sample_rd_value == 7'h34 || $changed(pulse_sel_reg)))
    else $error("T1 266-399 sample two wrong");
  a_rom_t1_long: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h5 && sample_rd_index == 5'h0B) |=>
    (sample_rd_value == 7'h58 || $changed(pulse_sel_reg)))
    else $error("T1 399-533 sample eleven wrong");
  a_rom_e1_coax: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h0 && sample_rd_index == 5'h05) |=>
    (sample_rd_value == 7'h30 || $changed(pulse_sel_reg)))
    else $error("E1 75 ohm sample five wrong");
  a_global_hiz: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !global_oe_pin |-> (!line_out_tip_oe && !line_out_ring_oe))
    else $error("driver enabled while global pin low");
  a_oc_hiz: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tx_overcurrent && cfg_reg.hiz_oc) |-> !line_out_tip_oe && !current_limit)
    else $error("driver enabled during over-current with high-z set");
  a_status_mirror: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce |=> (overcurrent_status_reg == $past(tx_overcurrent)))
    else $error("over-current status does not follow input");
  a_rise_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && tx_overcurrent && !overcurrent_status_reg) |=> overcurrent_irq_latched_reg)
    else $error("rising over-current not latched");
  a_irq_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (overcurrent_irq_latched_reg && !overcurrent_irq_mask_reg) |-> !irq_n)
    else $error("unmasked latched over-current without interrupt");
  a_single_ended: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_reg.single_ended |-> !line_out_ring_oe)
    else $error("ring driven in single-ended mode");
  a_read_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && go_reg && sample_dir_reg) |=> (sample_value_reg == $past(lookup_value)))
    else $error("sample read did not load data register");
  a_rom_t1_longest: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h6 && sample_rd_index == 5'h0B) |=>
    (sample_rd_value == 7'h5E || $changed(pulse_sel_reg)))
    else $error("T1 533-655 sample eleven wrong");
  a_rom_e1_twisted: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h1 && sample_rd_index == 5'h04) |=>
    (sample_rd_value == 7'h0F || $changed(pulse_sel_reg)))
    else $error("E1 120 ohm sample four wrong");
  a_rom_j1_table: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && pulse_sel_reg == 4'h7 && sample_rd_index == 5'h0A) |=>
    (sample_rd_value == 7'h4A || $changed(pulse_sel_reg)))
    else $error("J1 sample ten wrong");
  a_chan_hiz: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cfg_reg.oe |-> (!line_out_tip_oe && !line_out_ring_oe))
    else $error("driver enabled while channel enable clear");
  a_multifunction_show: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tmf_select_reg && overcurrent_status_reg) |-> tx_multifunction_pin)
    else $error("over-current not shown on multifunction pin");
  a_oc_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tx_overcurrent && !cfg_reg.hiz_oc && line_out_tip_oe) |-> current_limit)
    else $error("current limit missing while driving into over-current");

  c_oc_event: cover property (@(posedge sys_clk) disable iff (!rst_n)
    oc_event ##1 !irq_n);
  c_user_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
    go_reg && sample_dir_reg && pulse_sel_reg[txld_pkg::PULS_USER_BIT]);
  c_channel_off: cover property (@(posedge sys_clk) disable iff (!rst_n)
    global_oe_pin && !cfg_reg.oe);
  c_limit: cover property (@(posedge sys_clk) disable iff (!rst_n) current_limit);
endmodule // txld_ctrl

// [src/txld_pkg.sv]
// package of constants, templates and field layouts for the transmit line driver control
package txld_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TX_CONFIG_REG_0_OFS = 8'h00;
  localparam logic [7:0] PULSE_SEL_REG_OFS = 8'h04;
  localparam logic [7:0] WAVEFORM_ACCESS_CONTROL_OFS = 8'h08;
  localparam logic [7:0] WAVEFORM_SAMPLE_DATA_OFS = 8'h0C;
  localparam logic [7:0] STATUS_REG_0_OFS = 8'h10;
  localparam logic [7:0] IRQ_STATUS_REG_0_OFS = 8'h14;
  localparam logic [7:0] IRQ_EDGE_SELECT_REG_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_REG_0_OFS = 8'h1C;
  localparam logic [7:0] TMF_SELECT_REG_OFS = 8'h20;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_OE_BIT = 6;
  localparam int CFG_HIZ_OC_BIT = 4;
  localparam int CFG_SINGLE_BIT = 3;
  localparam int OC_BIT = 4;
  localparam int AWG_DIR_BIT = 5;
  localparam int AWG_GO_BIT = 6;
  localparam int PULS_USER_BIT = 3;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [6:0] TX_CONFIG_RST = 7'h40;
  localparam logic [3:0] PULSE_SEL_RST = 4'h0;
  localparam int NUM_SAMPLES = 20;
  localparam int NUM_TEMPLATES = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // termination codes, software's concern only
  localparam logic [2:0] TERM_T1_XFMR = 3'h0;
  localparam logic [2:0] TERM_J1_XFMR = 3'h1;
  localparam logic [2:0] TERM_E1_120_XFMR = 3'h2;
  localparam logic [2:0] TERM_E1_75_COAX = 3'h3;
  localparam logic [2:0] TERM_T1_NOXFMR = 3'h4;
  localparam logic [2:0] TERM_J1_NOXFMR = 3'h5;
  localparam logic [2:0] TERM_E1_NOXFMR = 3'h6;
  localparam logic [2:0] TERM_E1_EXT_RES = 3'h7;
  // ---------------------------------------------------------------
  // standard templates, row = template select, column = sample 1..20
  // ---------------------------------------------------------------
  localparam logic [6:0] TEMPLATE_ROM [NUM_TEMPLATES][NUM_SAMPLES] = '{
    '{7'h00, 7'h00, 7'h00, 7'h0C, 7'h30, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h00, 7'h00, 7'h00, 7'h0F, 7'h3C, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4A,
      7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00},
    '{7'h1B, 7'h2E, 7'h2C, 7'h2A, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25, 7'h50,
      7'h4F, 7'h4D, 7'h4A, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
    '{7'h1F, 7'h34, 7'h2F, 7'h2C, 7'h2B, 7'h2A, 7'h29, 7'h28, 7'h25, 7'h57,
      7'h53, 7'h50, 7'h4B, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
    '{7'h20, 7'h3B, 7'h35, 7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2A, 7'h28, 7'h58,
      7'h58, 7'h53, 7'h4C, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
    '{7'h20, 7'h3F, 7'h38, 7'h33, 7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h29, 7'h5F,
      7'h5E, 7'h57, 7'h4F, 7'h49, 7'h47, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
    '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4A,
      7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00}
  };
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic oe;
    logic power_off;
    logic hiz_oc;
    logic single_ended;
    logic [2:0] term;
  } txld_cfg_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } txld_ahb_req_t;
endpackage

// [verification/txld_line_model.sv]
// far-end line model: wire levels and a commanded over-current fault
`timescale 1ns/100ps
module txld_line_model (
  input wire logic sys_clk,
  input wire logic tip,
  input wire logic tip_oe,
  input wire logic ring,
  input wire logic ring_oe,
  input wire logic short_cmd,
  output logic wire_tip,
  output logic wire_ring,
  output logic tx_overcurrent
);
  logic tip_last = 1'b0;
  logic ring_last = 1'b0;
  initial tx_overcurrent = 1'b0;
  // a floating wire shows the inverse of its last level, so stale data never matches
  always @(posedge sys_clk) begin
    if (tip_oe) tip_last <= tip;
    if (ring_oe) ring_last <= ring;
    tx_overcurrent <= short_cmd; // detector lags the short by one cycle
  end
  assign wire_tip = tip_oe ? tip : ~tip_last;
  assign wire_ring = ring_oe ? ring : ~ring_last;
endmodule // txld_line_model

// [verification/tx_line_driver_control_tb.sv]
// self-checking bench for the transmit line driver control
`timescale 1ns/100ps
module tx_line_driver_control_tb;
  logic sys_clk, rst_n, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic global_oe_pin, tx_overcurrent, shaper_tip, shaper_ring, short_cmd;
  logic [4:0] sample_rd_index;
  logic [6:0] sample_rd_value;
  logic tip, tip_oe, ring, ring_oe, current_limit, tmf, irq_n, wire_tip, wire_ring;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // template select, sample number, expected value
  localparam logic [19:0] rom_chk [23] = '{20'h3011B, 20'h30A50, 20'h31400, 20'h4011F,
    20'h40234, 20'h40A57, 20'h50120, 20'h5023B, 20'h50A58, 20'h50B58, 20'h6023F,
    20'h60A5F, 20'h60B5E, 20'h0040C, 20'h00530, 20'h00600, 20'h1040F, 20'h1053C,
    20'h10300, 20'h70117, 20'h70A4A, 20'h71300, 20'h71400};
  assign hready = hreadyout;
  txld_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .global_oe_pin(global_oe_pin),
    .tx_overcurrent(tx_overcurrent), .shaper_tip(shaper_tip), .shaper_ring(shaper_ring),
    .sample_rd_index(sample_rd_index), .sample_rd_value(sample_rd_value),
    .line_out_tip(tip), .line_out_tip_oe(tip_oe), .line_out_ring(ring),
    .line_out_ring_oe(ring_oe), .current_limit(current_limit),
    .tx_multifunction_pin(tmf), .irq_n(irq_n));
  txld_line_model line (.sys_clk(sys_clk), .tip(tip), .tip_oe(tip_oe), .ring(ring),
    .ring_oe(ring_oe), .short_cmd(short_cmd), .wire_tip(wire_tip), .wire_ring(wire_ring),
    .tx_overcurrent(tx_overcurrent));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; values are taken just before each edge so no race decides them
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    logic r;
    logic e;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= txld_pkg::HTRANS_NONSEQ;
    do begin
      @(negedge sys_clk);
      r = hready;
      @(posedge sys_clk);
    end while (!r);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge sys_clk);
      r = hready;
      q = hrdata;
      e = hresp;
      @(posedge sys_clk);
    end while (!r);
    chk(32'h0, {31'h0, e}); // response is always OKAY
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h00000000, q);
    chk(exp, q);
  endtask
  // driver pins: current limit, tip enable, ring enable, multifunction, interrupt
  task automatic pins(input logic [4:0] exp);
    @(negedge sys_clk);
    chk({27'h0, exp}, {27'h0, current_limit, tip_oe, ring_oe, tmf, irq_n});
    @(posedge sys_clk);
  endtask
  task automatic sample(input logic [4:0] idx, input logic [6:0] exp);
    sample_rd_index <= idx;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({25'h0, exp}, {25'h0, sample_rd_value});
    @(posedge sys_clk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(8'h00, 32'h00000040);
    rd(8'h1C, 32'h00000010);
    rd(8'h3C, 32'h00000000); // unmapped reads zero
    pins(5'b01101);
  endtask
  task automatic t_rom;
    for (int i = 0; i < 23; i++) begin
      wr(8'h04, {28'h0, rom_chk[i][19:16]});
      sample(rom_chk[i][12:8], rom_chk[i][6:0]);
    end
  endtask
  task automatic t_user;
    wr(8'h04, 32'h00000005);
    wr(8'h08, 32'h0000006B); // read sample 11
    rd(8'h0C, 32'h00000058);
    wr(8'h0C, 32'h0000007F); // -63 in signed magnitude
    wr(8'h08, 32'h00000043); // write sample 3
    wr(8'h04, 32'h00000008);
    sample(5'h03, 7'h7F);
    wr(8'h0C, 32'h00000000); // clear so the read-back must reload
    wr(8'h08, 32'h00000063);
    rd(8'h0C, 32'h0000007F);
  endtask
  task automatic t_hiz;
    shaper_tip <= 1'b1;
    global_oe_pin <= 1'b0;
    pins(5'b00001);
    @(negedge sys_clk);
    chk(32'h1, {31'h0, tip});
    @(posedge sys_clk);
    global_oe_pin <= 1'b1;
    wr(8'h00, 32'h00000000);
    pins(5'b00001);
    wr(8'h00, 32'h0000004B); // single-ended coax with its termination code
    pins(5'b01001);
    @(negedge sys_clk);
    chk(32'h3, {30'h0, wire_tip, wire_ring});
    @(posedge sys_clk);
    wr(8'h00, 32'h00000060);
    pins(5'b00001); // power-down also floats the driver
    wr(8'h00, 32'h00000040);
    pins(5'b01101);
    rd(8'h00, 32'h00000040);
    ce <= 1'b0;
    wr(8'h00, 32'h00000000);
    ce <= 1'b1;
    rd(8'h00, 32'h00000040); // write lost while clock enable is low
  endtask
  task automatic t_oc;
    wr(8'h20, 32'h00000001);
    short_cmd <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pins(5'b11111);
    rd(8'h10, 32'h00000010);
    rd(8'h14, 32'h00000010);
    wr(8'h1C, 32'h00000000);
    pins(5'b11110);
    wr(8'h00, 32'h00000050);
    pins(5'b00010);
    wr(8'h00, 32'h00000040);
    wr(8'h14, 32'h00000010);
    short_cmd <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h10, 32'h00000000);
    rd(8'h14, 32'h00000000);
    wr(8'h18, 32'h00000010);
    short_cmd <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(8'h14, 32'h00000010);
    short_cmd <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h14, 32'h00000010);
    pins(5'b01100);
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // a hung handshake ends the run here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    {rst_n, hwrite, shaper_tip, shaper_ring, short_cmd} = 5'h00;
    {ce, hsel, global_oe_pin} = 3'h7;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    sample_rd_index = 5'h01;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_rom;
    t_user;
    t_hiz;
    t_oc;
    final_report;
  end
endmodule // tx_line_driver_control_tb
